// [design/dswp_pkg.sv]
// Package for the drive status word and process-data mapping block.
// Assumes a single core clock; registers are named by object index, field offsets are bit positions, not byte addresses.
package dswp_pkg;
  // Object indices of the mapped registers
  localparam logic [15:0] IDX_TARGET_POS  = 16'h2001;
  localparam logic [15:0] IDX_ACTUAL_POS  = 16'h2003;
  localparam logic [15:0] IDX_CONTROL     = 16'h2024;
  localparam logic [15:0] IDX_STATUS      = 16'h2025;
  localparam logic [15:0] IDX_SPEED       = 16'h2030;
  // Receive object field positions
  localparam int RX_CTRL_LSB = 0;
  localparam int RX_TGT_LSB  = 16;
  localparam int RX_WIDTH    = 48;
  // Transmit object field positions
  localparam int TX_STAT_LSB = 0;
  localparam int TX_SPD_LSB  = 16;
  localparam int TX_POS_LSB  = 32;
  localparam int TX_WIDTH    = 64;
  // Status and control bit positions
  localparam int ST_TARGET   = 0;
  localparam int ST_DRAG     = 1;
  localparam int ST_JOG_REV  = 2;
  localparam int ST_JOG_FWD  = 3;
  localparam int ST_TORQUE   = 4;
  localparam int CW_ACK      = 14;
  // Reset values
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  // Acknowledge toggle tracker states
  typedef enum logic [1:0] {
    DSWP_ACK_IDLE = 2'b00,
    DSWP_ACK_HIGH = 2'b01,
    DSWP_ACK_DONE = 2'b11
  } dswp_ack_t;
endpackage

// [design/dswp_torque_latch.sv]
// Torque-off enabling status with acknowledge-dependent failure latching.
// Assumes inputs synchronous to core_clk; validInput already folds test pulses.
`timescale 1ns/100ps
module dswp_torque_latch (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic clkEn,
  // Conditions
  input  wire logic validInput,
  input  wire logic ackBit,
  input  wire logic moving,
  input  wire logic runCmd,
  // Result
  output logic      enableFlag
);
  typedef struct packed {
    logic             fail;
    dswp_pkg::dswp_ack_t ackSt;
  } dswp_tl_t;
  dswp_tl_t stReg;
  dswp_tl_t stNext;

  // Latch a failure only with acknowledge low and motion or a run request
  always_comb
  begin
    stNext = stReg;
    case (stReg.ackSt)
      dswp_pkg::DSWP_ACK_IDLE: if (ackBit) stNext.ackSt = dswp_pkg::DSWP_ACK_HIGH;
      dswp_pkg::DSWP_ACK_HIGH: if (!ackBit) stNext.ackSt = dswp_pkg::DSWP_ACK_DONE;
      dswp_pkg::DSWP_ACK_DONE: stNext.ackSt = ackBit ? dswp_pkg::DSWP_ACK_HIGH
                                                     : dswp_pkg::DSWP_ACK_IDLE;
      default:                 stNext.ackSt = dswp_pkg::DSWP_ACK_IDLE;
    endcase
    if (!ackBit && !validInput && (moving || runCmd))
      stNext.fail = 1'b1;
    // Clear on the high-to-low step itself so a failure found after it survives
    else if ((runCmd && validInput) || (stReg.ackSt == dswp_pkg::DSWP_ACK_HIGH && !ackBit))
      stNext.fail = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      stReg <= '{fail: 1'b0, ackSt: dswp_pkg::DSWP_ACK_IDLE};
    else if (clkEn)
      stReg <= stNext;
  end

  // Acknowledge high shows the input directly; low also masks a latched failure
  assign enableFlag = ackBit ? validInput : (validInput && !stReg.fail);

  AST_ACK_DIRECT: assert property (@(posedge core_clk) disable iff (!nrst)
    ackBit |-> enableFlag == validInput)
    else $error("enable flag differs from input while acknowledged");
  AST_FAIL_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && !ackBit && !validInput && moving) |=> stReg.fail)
    else $error("failure not latched during motion");
endmodule

// [design/dswp_status_core.sv]
// Status word and cyclic process-data mapping for a positioning drive.
// Assumes motion logic supplies event pulses and levels synchronous to core_clk.
// Behaviour
// - Receive object: control word in bits 0-15, target value 16-47, fixed.
// - Transmit object: status 0-15, speed 16-31, position 32-63, fixed.
// - Target-reached set on successful positioning, not after manual run unless at limit.
// - After standstill displacement, re-set when readjusting and error within window.
// - Target-reached and block error together: only target-reached is set.
// - Target-reached cleared by far new target, manual run, invalid target, turning.
// - Drag error set when lag exceeds limit outside braking; cleared by new run.
// - Status bits 2 and 3 mirror reverse and forward jog key inputs.
// - With acknowledge high, status bit 4 shows the torque-off enabling input.
// - Acknowledge low: failure latched on motion or run; cleared by run or toggle.
`timescale 1ns/100ps
module dswp_status_core #(
  parameter int POS_W = 32,
  parameter int SPD_W = 16
) (
  // Clock, reset, enable
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  input  wire logic                    clkEn,
  // Cyclic exchange
  input  wire logic                    pdoStrobe,
  input  wire logic [dswp_pkg::RX_WIDTH-1:0] rxPdo,
  output logic [dswp_pkg::TX_WIDTH-1:0] txPdo,
  // Drive state
  input  wire logic [POS_W-1:0]        actualPos,
  input  wire logic [POS_W-1:0]        setpointPos,
  input  wire logic [SPD_W-1:0]        currentSpeed,
  input  wire logic [POS_W-1:0]        posWindow,
  input  wire logic [POS_W-1:0]        dragLimit,
  input  wire logic                    moving,
  input  wire logic                    braking,
  // Motion events (one-cycle pulses); atLimit is a level
  input  wire logic                    runCmd,
  input  wire logic                    newTarget,
  input  wire logic                    targetDone,
  input  wire logic                    manualEnd,
  input  wire logic                    atLimit,
  input  wire logic                    manualRun,
  input  wire logic                    invalidTarget,
  input  wire logic                    turnedAtRest,
  input  wire logic                    readjustOn,
  input  wire logic                    blockEvent,
  // Pins
  input  wire logic                    jogRevKey,
  input  wire logic                    jogFwdKey,
  input  wire logic                    torqueOffValid,
  // Register view
  output logic [15:0]                  driveControlWord,
  output logic [POS_W-1:0]             targetPositionValue,
  output logic [15:0]                  driveStatusWord,
  output logic                         blockErrorFlag
);
  localparam int TX_WIDTH_L = dswp_pkg::TX_WIDTH;
  typedef struct packed {
    logic [15:0]      ctrl;
    logic [POS_W-1:0] target;
    logic             reached;
    logic             drag;
    logic             block;
    logic             displaced;
    logic [TX_WIDTH_L-1:0] tx;
  } dswp_core_t;

  dswp_core_t rReg;
  dswp_core_t rNext;
  logic       torqueFlag;
  logic [POS_W-1:0] posErr;
  logic [POS_W-1:0] lagErr;
  logic [POS_W-1:0] tgtDist;
  logic [15:0]      statusNow;
  logic             reachSet;

  // Absolute differences
  function automatic logic [POS_W-1:0] absDiff(input logic [POS_W-1:0] a,
                                               input logic [POS_W-1:0] b);
    logic [POS_W-1:0] d;
    d = a - b;
    return d[POS_W-1] ? (POS_W)'(~d + 1'b1) : d;
  endfunction

  assign posErr  = absDiff(actualPos, rReg.target);
  assign lagErr  = absDiff(setpointPos, actualPos);
  assign tgtDist = absDiff(rxPdo[dswp_pkg::RX_TGT_LSB +: POS_W], actualPos);

  // Any set condition of target reached in this update; block error yields to it
  assign reachSet = ((targetDone && !manualEnd) || (manualEnd && atLimit))
                  || (rReg.displaced && !moving && readjustOn && posErr <= posWindow);

  dswp_torque_latch uTorque (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .clkEn      (clkEn),
    .validInput (torqueOffValid),
    .ackBit     (rReg.ctrl[dswp_pkg::CW_ACK]),
    .moving     (moving),
    .runCmd     (runCmd),
    .enableFlag (torqueFlag)
  );

  // Live status word; key bits and bit 4 follow their sources
  always_comb
  begin
    statusNow = dswp_pkg::STATUS_RST;
    statusNow[dswp_pkg::ST_TARGET]  = rReg.reached;
    statusNow[dswp_pkg::ST_DRAG]    = rReg.drag;
    statusNow[dswp_pkg::ST_JOG_REV] = jogRevKey;
    statusNow[dswp_pkg::ST_JOG_FWD] = jogFwdKey;
    statusNow[dswp_pkg::ST_TORQUE]  = torqueFlag;
  end

  // Flag updates; set conditions are evaluated last so they win over clears
  always_comb
  begin
    rNext = rReg;
    if (pdoStrobe)
    begin
      rNext.ctrl = rxPdo[dswp_pkg::RX_CTRL_LSB +: 16];
      rNext.target = rxPdo[dswp_pkg::RX_TGT_LSB +: POS_W];
      if (tgtDist > posWindow)
        rNext.reached = 1'b0;
    end
    if (runCmd)
    begin
      rNext.drag  = 1'b0;
      rNext.block = 1'b0;
      rNext.displaced = 1'b0;
    end
    if (manualRun || invalidTarget)
      rNext.reached = 1'b0;
    if (turnedAtRest)
    begin
      rNext.reached = 1'b0;
      rNext.displaced = 1'b1;
    end
    if (moving && !braking && lagErr > dragLimit)
      rNext.drag = 1'b1;
    if ((targetDone && !manualEnd) || (manualEnd && atLimit))
      rNext.reached = 1'b1;
    else if (rReg.displaced && !moving && readjustOn && posErr <= posWindow)
      rNext.reached = 1'b1;
    if (blockEvent && !reachSet)
      rNext.block = 1'b1;
    if (pdoStrobe)
    begin
      rNext.tx[dswp_pkg::TX_STAT_LSB +: 16]   = statusNow;
      rNext.tx[dswp_pkg::TX_SPD_LSB +: 16]    = 16'(currentSpeed);
      rNext.tx[dswp_pkg::TX_POS_LSB +: 32]    = 32'(actualPos);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      rReg <= '0;
    else if (clkEn)
      rReg <= rNext;
  end

  // Register view outputs
  assign txPdo               = rReg.tx;
  assign driveControlWord    = rReg.ctrl;
  assign targetPositionValue = rReg.target;
  assign driveStatusWord     = statusNow;
  assign blockErrorFlag      = rReg.block;

  sequence runSeq;
    clkEn && runCmd && !(moving && !braking && lagErr > dragLimit);
  endsequence

  AST_KEY_REV: assert property (@(posedge core_clk) disable iff (!nrst)
    driveStatusWord[2] == jogRevKey)
    else $error("reverse key bit wrong");
  AST_KEY_FWD: assert property (@(posedge core_clk) disable iff (!nrst)
    driveStatusWord[3] == jogFwdKey)
    else $error("forward key bit wrong");
  AST_DRAG_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
    runSeq |=> !driveStatusWord[1])
    else $error("drag not cleared on run");
  AST_REACH_SET: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && targetDone && !manualEnd) |=> driveStatusWord[0])
    else $error("target reached not set");
  AST_MANUAL_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && manualRun && !targetDone && !manualEnd && !rReg.displaced)
      |=> !driveStatusWord[0])
    else $error("manual run kept target reached");
  AST_PRIO: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && blockEvent && targetDone && !manualEnd) |=> !blockErrorFlag)
    else $error("block set alongside target reached");
  AST_TX_STAT: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && pdoStrobe) |=> txPdo[15:0] == $past(statusNow))
    else $error("status word not placed in transmit object");
  AST_RX_CTRL: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && pdoStrobe) |=> driveControlWord == $past(rxPdo[15:0]))
    else $error("control word not taken from receive object");

  // Named steps for the checks below; each is one sampled condition
  // Exchange edge and quiet edge
  sequence strobeSeq;
    clkEn && pdoStrobe;
  endsequence

  sequence idleSeq;
    clkEn && !pdoStrobe;
  endsequence

  // A new target far from the shaft, with nothing setting the flag again
  sequence farTargetSeq;
    clkEn && pdoStrobe && tgtDist > posWindow && !reachSet;
  endsequence

  // End of a manual run away from the range limit
  sequence manualFreeSeq;
    clkEn && manualEnd && !atLimit && !driveStatusWord[0] && !rReg.displaced;
  endsequence

  // Shaft back inside the window after an external push
  sequence readjustSeq;
    clkEn && rReg.displaced && !moving && readjustOn && posErr <= posWindow;
  endsequence

  // Lag beyond the limit while driving; braking is excluded on purpose
  sequence dragSeq;
    clkEn && moving && !braking && lagErr > dragLimit;
  endsequence

  // Torque-off bit is the latch result; unmapped bits stay quiet
  AST_TORQUE_BIT: assert property (@(posedge core_clk) disable iff (!nrst)
    driveStatusWord[4] == torqueFlag)
    else $error("torque bit differs from enabling status");
  AST_ACK_VIEW: assert property (@(posedge core_clk) disable iff (!nrst)
    rReg.ctrl[dswp_pkg::CW_ACK] |-> driveStatusWord[4] == torqueOffValid)
    else $error("acknowledged torque bit not direct");
  AST_LOW_VIEW: assert property (@(posedge core_clk) disable iff (!nrst)
    !torqueOffValid |-> !driveStatusWord[4])
    else $error("torque bit high with invalid input");
  AST_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    driveStatusWord[15:5] == 11'h000)
    else $error("unmapped status bits not zero");

  // Transmit fields are the values seen at the exchange edge, held in between
  // so the master reads one consistent snapshot
  AST_TX_SPD: assert property (@(posedge core_clk) disable iff (!nrst)
    strobeSeq |=> txPdo[31:16] == $past(currentSpeed))
    else $error("speed not placed in transmit object");
  AST_TX_POS: assert property (@(posedge core_clk) disable iff (!nrst)
    strobeSeq |=> txPdo[63:32] == $past(actualPos))
    else $error("position not placed in transmit object");
  AST_TX_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    idleSeq |=> $stable(txPdo))
    else $error("transmit object changed between exchanges");
  AST_RX_TGT: assert property (@(posedge core_clk) disable iff (!nrst)
    strobeSeq |=> targetPositionValue == $past(rxPdo[47:16]))
    else $error("target not taken from receive object");
  AST_CTRL_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    idleSeq |=> $stable(driveControlWord) && $stable(targetPositionValue))
    else $error("received fields changed without exchange");

  // Target reached: clears lose against any set in the same update
  AST_FAR_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
    farTargetSeq |=> !driveStatusWord[0])
    else $error("far target kept target reached");
  AST_INVALID_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && invalidTarget && !reachSet) |=> !driveStatusWord[0])
    else $error("invalid target kept target reached");
  AST_TURN_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && turnedAtRest && !reachSet) |=> !driveStatusWord[0])
    else $error("turning kept target reached");
  AST_REACH_KEEP: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && driveStatusWord[0] && !pdoStrobe && !manualRun && !invalidTarget
      && !turnedAtRest) |=> driveStatusWord[0])
    else $error("target reached lost without cause");
  AST_MANUAL_END: assert property (@(posedge core_clk) disable iff (!nrst)
    manualFreeSeq |=> !driveStatusWord[0])
    else $error("manual run end set target reached");
  AST_LIMIT_SET: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && manualEnd && atLimit) |=> driveStatusWord[0])
    else $error("manual run at limit not reached");
  AST_READJUST: assert property (@(posedge core_clk) disable iff (!nrst)
    readjustSeq |=> driveStatusWord[0])
    else $error("readjust did not set target reached");

  // Drag error: set while lagging, held until the next run command
  AST_DRAG_SET: assert property (@(posedge core_clk) disable iff (!nrst)
    dragSeq |=> driveStatusWord[1])
    else $error("drag error not set");
  AST_DRAG_KEEP: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && driveStatusWord[1] && !runCmd) |=> driveStatusWord[1])
    else $error("drag error lost without run");
  AST_BRAKE_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && braking && !driveStatusWord[1]) |=> !driveStatusWord[1])
    else $error("drag error set while braking");

  // Block error alone is recorded; it only yields to a same-update reach
  AST_BLOCK_SET: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && blockEvent && !reachSet) |=> blockErrorFlag)
    else $error("block error not set");
  AST_BLOCK_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
    (clkEn && runCmd && !blockEvent) |=> !blockErrorFlag)
    else $error("block error not cleared on run");
endmodule

// [tb/dswp_master_model.sv]
// Fieldbus master model: runs cyclic process-data exchanges with the drive block.
// Assumes core_clk comes from the bench; requests change at the falling edge.
`timescale 1ns/100ps
module dswp_master_model (
  // Clock
  input  wire logic        core_clk,
  // Exchange
  output logic             pdoStrobe,
  output logic [47:0]      rxPdo,
  input  wire logic [63:0] txPdo
);
  // Idle until the bench asks for an exchange
  initial
  begin
    pdoStrobe = 1'b0;
    rxPdo     = 48'h000000000000;
  end

  // One exchange: control word low, target value above it
  task automatic exchange(input logic [15:0] ctrl, input logic [31:0] tgt,
                          output logic [63:0] tx);
  begin
    @(negedge core_clk);
    pdoStrobe = 1'b1;
    rxPdo     = {tgt, ctrl};
    @(negedge core_clk);
    pdoStrobe = 1'b0;
    rxPdo     = ~rxPdo; // Stale bits inverted so a late capture shows up
    tx        = txPdo;
  end
  endtask
endmodule

// [tb/dswp_tb.sv]
// Self-checking bench for the status word and process-data block.
// Assumes the master model drives exchanges; events are pulsed at the falling edge.
`timescale 1ns/100ps
module tb;
  logic        core_clk, nrst, moving, braking, readjustOn, atLimit;
  logic        jogRevKey, jogFwdKey, torqueOffValid, pdoStrobe, blockErrorFlag;
  logic [6:0]  ev;
  logic [47:0] rxPdo;
  logic [63:0] txPdo, tx;
  logic [31:0] actualPos, setpointPos, targetPositionValue;
  logic [15:0] driveControlWord, driveStatusWord;
  int          bad_count, n_compared;

  dswp_master_model master (.core_clk(core_clk), .pdoStrobe(pdoStrobe), .rxPdo(rxPdo),
    .txPdo(txPdo));
  // Window 10, drag limit 50, speed fixed so the transmit field is known
  dswp_status_core i_dswp_status_core (.core_clk(core_clk), .nrst(nrst), .clkEn(1'b1),
    .pdoStrobe(pdoStrobe), .rxPdo(rxPdo), .txPdo(txPdo), .actualPos(actualPos),
    .setpointPos(setpointPos), .currentSpeed(16'h0BCD), .posWindow(32'h0000000A),
    .dragLimit(32'h00000032), .moving(moving), .braking(braking), .runCmd(ev[0]),
    .newTarget(1'b0), .targetDone(ev[1]), .manualEnd(ev[2]), .atLimit(atLimit),
    .manualRun(ev[3]), .invalidTarget(ev[4]), .turnedAtRest(ev[5]),
    .readjustOn(readjustOn), .blockEvent(ev[6]), .jogRevKey(jogRevKey),
    .jogFwdKey(jogFwdKey), .torqueOffValid(torqueOffValid),
    .driveControlWord(driveControlWord), .targetPositionValue(targetPositionValue),
    .driveStatusWord(driveStatusWord), .blockErrorFlag(blockErrorFlag));

  // Clock at 25 MHz
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task automatic st(input logic [15:0] e);
    chk({48'h000000000000, driveStatusWord}, {48'h000000000000, e});
  endtask

  // One-cycle event pulse; result is settled at the closing falling edge
  task automatic pulse(input logic [6:0] m);
  begin
    @(negedge core_clk);
    ev = m;
    @(negedge core_clk);
    ev = 7'h00;
  end
  endtask

  task automatic final_report();
  begin
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  // Watchdog: the sequence needs a few microseconds only
  initial
  begin
    #200000;
    bad_count++;
    final_report();
  end

  // Main sequence
  initial
  begin
    {nrst, moving, braking, readjustOn, atLimit, jogRevKey, jogFwdKey} = 7'h00;
    {ev, bad_count, n_compared} = '0;
    torqueOffValid = 1'b1;
    actualPos      = 32'h00000064;
    setpointPos    = 32'h00000064;
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    st(16'h0010);
    for (int i = 0; i < 4; i++)
    begin
      {jogFwdKey, jogRevKey} = i[1:0];
      @(negedge core_clk);
      st({11'h000, 1'b1, i[1:0], 2'b00});
    end
    {jogFwdKey, jogRevKey} = 2'b00;
    master.exchange(16'h4004, 32'h00000064, tx);
    chk({16'h0000, targetPositionValue, driveControlWord}, 64'h0000000000644004);
    chk(tx, 64'h000000640BCD0010);
    torqueOffValid = 1'b0;
    @(negedge core_clk);
    st(16'h0000);
    torqueOffValid = 1'b1;
    @(negedge core_clk);
    st(16'h0010);
    pulse(7'h02);
    st(16'h0011);
    pulse(7'h08);
    st(16'h0010);
    pulse(7'h04);
    st(16'h0010);
    atLimit = 1'b1;
    pulse(7'h04);
    st(16'h0011);
    atLimit = 1'b0;
    pulse(7'h10);
    st(16'h0010);
    pulse(7'h42);
    chk({blockErrorFlag, driveStatusWord}, {1'b0, 16'h0011});
    pulse(7'h40);
    chk({blockErrorFlag, driveStatusWord}, {1'b1, 16'h0011});
    pulse(7'h20);
    st(16'h0010);
    readjustOn = 1'b1;
    @(negedge core_clk);
    st(16'h0011);
    readjustOn  = 1'b0;
    moving      = 1'b1;
    setpointPos = 32'h000000C8;
    @(negedge core_clk);
    st(16'h0013);
    braking = 1'b1;
    pulse(7'h01);
    st(16'h0011);
    {moving, braking} = 2'b00;
    setpointPos       = 32'h00000064;
    // Failure latching with acknowledge low, cleared by toggle then by run
    master.exchange(16'h0000, 32'h00000064, tx);
    for (int k = 0; k < 2; k++)
    begin
      {moving, torqueOffValid} = 2'b10;
      @(negedge core_clk);
      {moving, torqueOffValid} = 2'b01;
      @(negedge core_clk);
      st(16'h0001);
      if (k == 0)
      begin
        master.exchange(16'h4000, 32'h00000064, tx);
        master.exchange(16'h0000, 32'h00000064, tx);
        @(negedge core_clk);
      end
      else
        pulse(7'h01);
      st(16'h0011);
    end
    final_report();
  end
endmodule
